// >>> logic/gbsms_top.sv
/*
  Gain bank and servo mode selector: decodes the gain-bank field and the
  servo mode request of each servo command I/O word, holds four banks of
  gain parameters, drives the active bank's gains and the servo mode.
  Assumes the word, its strobe and the motion command levels come from
  fieldbus logic on clk; software reaches the registers over AXI4-Lite.
*/
`include "gbsms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - the active gain bank comes from the 4-bit gain-bank field of each command word.
// - bits 9 and 8 of the command word pick gain bank 0, 1, 2 or 3.
// - each bank holds its own speed gain, integral time, position gain and torque filter.
// - in manual switching, bit 30 of the command word turns servo mode off at 0, on at 1.
// - the low digit of the switching setting picks manual (0) or automatic (1) on restart.
// - in automatic switching, interpolation and orientation commands force servo mode on.
// - in automatic switching, clearing the request during those commands raises a warning.
module gbsms_top #(
  parameter int SETTLE_CYCLES = `GBSMS_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire gbsms_pkg::gbsms_axi_req_t axi_req,
  output gbsms_pkg::gbsms_axi_rsp_t axi_rsp,
  input wire logic cmd_valid,
  input wire logic [31:0] servo_command_io_word,
  input wire logic interpolation_feed_command,
  input wire logic spindle_orientation_command,
  input wire logic quick_orientation_command,
  output gbsms_pkg::gbsms_gain_t active_gains,
  output logic [1:0] active_bank,
  output logic servo_mode_on,
  output logic servo_mode_warning,
  output logic bank_settled,
  output logic reverse_torque_limit_request,
  output logic forward_torque_limit_request,
  output logic speed_loop_p_control_request
);
  import gbsms_pkg::*;

  gbsms_state_t s;
  gbsms_state_t next_s;
  gbsms_wr_t wr;
  logic wr_err;
  logic rd_err;
  logic [31:0] rd_data;
  logic auto_mode;
  logic motion_cmd;
  logic restart_hit;

  // true for every address that holds a register
  function automatic logic addr_mapped(input logic [`GBSMS_ADDR_W-1:0] a);
    addr_mapped = (a[7:6] == 2'b01) || (a[7:2] == `GBSMS_OFF_CTRL >> 2) ||
                  (a[7:2] == `GBSMS_OFF_STATUS >> 2) || (a[7:2] == `GBSMS_OFF_CMDWORD >> 2);
  endfunction : addr_mapped

  // byte-lane merge of a write into an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    lane_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        lane_merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction : lane_merge

  // register bus slave
  gbsms_axil_slave u_slave (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .req(axi_req),
    .rsp(axi_rsp),
    .wr(wr),
    .wr_err(wr_err),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  assign wr_err = !addr_mapped(wr.addr);
  assign rd_err = !addr_mapped(axi_req.araddr);
  assign auto_mode = (s.auto_sel == `GBSMS_AUTO_ON);
  assign motion_cmd = interpolation_feed_command || spindle_orientation_command ||
                      quick_orientation_command;
  assign restart_hit = wr.en && !wr_err && (wr.addr[7:2] == `GBSMS_OFF_CTRL >> 2) &&
                       wr.strb[1] && wr.data[`GBSMS_CTRL_RESTART_BIT];

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (axi_req.araddr[7:6] == 2'b01) begin
      rd_data[`GBSMS_PW-1:0] = s.params[axi_req.araddr[5:2]];
    end else if (axi_req.araddr[7:2] == `GBSMS_OFF_CTRL >> 2) begin
      rd_data[3:0] = s.pend_sel;
    end else if (axi_req.araddr[7:2] == `GBSMS_OFF_STATUS >> 2) begin
      rd_data[1:0] = s.gain_field[1:0];
      rd_data[7:4] = s.gain_field;
      rd_data[`GBSMS_STAT_SERVO_BIT] = s.servo_on;
      rd_data[`GBSMS_STAT_AUTO_BIT] = auto_mode;
      rd_data[`GBSMS_STAT_SETTLED_BIT] = s.settled;
      rd_data[`GBSMS_STAT_WARN_BIT] = s.warn;
    end else if (axi_req.araddr[7:2] == `GBSMS_OFF_CMDWORD >> 2) begin
      rd_data = s.last_word;
    end
  end

  // next state: register writes, command word decode, servo mode, gains
  always_comb begin
    logic [31:0] merged;
    logic [3:0] pidx;
    merged = 32'h0000_0000;
    pidx = 4'h0;
    next_s = s;
    if (wr.en && !wr_err) begin
      if (wr.addr[7:6] == 2'b01) begin
        pidx = wr.addr[5:2];
        merged = lane_merge({{(32-`GBSMS_PW){1'b0}}, s.params[pidx]}, wr.data, wr.strb);
        next_s.params[pidx] = merged[`GBSMS_PW-1:0];
      end else if (wr.addr[7:2] == `GBSMS_OFF_CTRL >> 2) begin
        if (wr.strb[0]) begin
          next_s.pend_sel = wr.data[3:0];
        end
      end else if (wr.addr[7:2] == `GBSMS_OFF_STATUS >> 2) begin
        if (wr.strb[2] && wr.data[`GBSMS_STAT_WARN_BIT]) begin
          next_s.warn = 1'b0; // write one to clear
        end
      end
    end
    // the setting only takes hold on a restart
    if (restart_hit) begin
      next_s.auto_sel = next_s.pend_sel;
    end
    // latch the fields of a new command word, reserved bits dropped
    if (cmd_valid) begin
      next_s.last_word = servo_command_io_word & `GBSMS_CMD_USED_MASK;
      next_s.gain_field = servo_command_io_word[`GBSMS_CMD_GSEL_LSB +: 4];
      next_s.servo_req = servo_command_io_word[`GBSMS_CMD_SVMOD_BIT];
    end
    // a changed field restarts the window, even one already at full count
    if (cmd_valid && servo_command_io_word[`GBSMS_CMD_GSEL_LSB +: 4] != s.gain_field) begin
      next_s.settle_cnt = `GBSMS_SETTLE_W'(SETTLE_CYCLES);
    end else if (s.settle_cnt != '0) begin
      next_s.settle_cnt = s.settle_cnt - `GBSMS_SETTLE_W'(1);
    end
    next_s.settled = (next_s.settle_cnt == '0);
    // servo mode: manual follows the request, automatic forces it on during motion commands
    if (auto_mode && motion_cmd) begin
      next_s.servo_on = 1'b1;
      if (!next_s.servo_req) begin
        next_s.warn = 1'b1;
      end
    end else begin
      next_s.servo_on = next_s.servo_req;
    end
    // gains of the bank picked by bits 9 and 8
    next_s.gain_out.spd_gain = s.params[{next_s.gain_field[1:0], 2'd0}];
    next_s.gain_out.spd_integ = s.params[{next_s.gain_field[1:0], 2'd1}];
    next_s.gain_out.pos_gain = s.params[{next_s.gain_field[1:0], 2'd2}];
    next_s.gain_out.trq_filt = s.params[{next_s.gain_field[1:0], 2'd3}];
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s.pend_sel <= `GBSMS_AUTO_OFF;
      s.auto_sel <= `GBSMS_AUTO_OFF;
      s.gain_field <= 4'h0;
      s.servo_req <= 1'b0;
      s.servo_on <= 1'b0;
      s.warn <= 1'b0;
      s.last_word <= 32'h0000_0000;
      s.settle_cnt <= '0;
      s.settled <= 1'b1;
      s.params <= {16{`GBSMS_PARAM_RST}};
      s.gain_out <= {4{`GBSMS_PARAM_RST}};
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign active_gains = s.gain_out;
  assign active_bank = s.gain_field[1:0];
  assign servo_mode_on = s.servo_on;
  assign servo_mode_warning = s.warn;
  assign bank_settled = s.settled;
  assign reverse_torque_limit_request = s.last_word[`GBSMS_CMD_NCL_BIT];
  assign forward_torque_limit_request = s.last_word[`GBSMS_CMD_PCL_BIT];
  assign speed_loop_p_control_request = s.last_word[`GBSMS_CMD_PPI_BIT];

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence word_taken;
    ce && cmd_valid;
  endsequence

  sequence manual_word;
    ce && cmd_valid && !auto_mode;
  endsequence

  sequence forced_drop;
    ce && cmd_valid && auto_mode && motion_cmd && !servo_command_io_word[30];
  endsequence

  bank_field_a: assert property (word_taken |=> s.gain_field == $past(servo_command_io_word[11:8]))
    else $error("gain bank field not taken from command word");

  bank_decode_a: assert property (word_taken |=> active_bank == $past(servo_command_io_word[9:8]))
    else $error("active bank does not follow bits 9 and 8");

  bank_gain_a: assert property (ce && !cmd_valid && !wr.en |=>
      active_gains.pos_gain == $past(s.params[{s.gain_field[1:0], 2'd2}]))
    else $error("position gain not from the active bank");

  manual_servo_a: assert property (manual_word |=> servo_mode_on == $past(servo_command_io_word[30]))
    else $error("manual servo mode does not follow the request bit");

  restart_only_a: assert property (ce && !restart_hit |=> $stable(s.auto_sel))
    else $error("switching method changed without restart");

  auto_force_a: assert property (ce && auto_mode && motion_cmd |=> servo_mode_on)
    else $error("servo mode not forced on by motion command");

  auto_warn_a: assert property (forced_drop |=> servo_mode_on && servo_mode_warning)
    else $error("refused disable did not raise the warning");

  manual_nowarn_a: assert property (ce && !auto_mode && !servo_mode_warning |=> !servo_mode_warning)
    else $error("warning raised under manual switching");

  settle_a: assert property (word_taken ##0 (servo_command_io_word[11:8] != s.gain_field) |=>
      !bank_settled ##1 (!ce || !bank_settled))
    else $error("bank settle window not started");

  freeze_a: assert property (!ce |=> $stable(s))
    else $error("state moved while clock enable was low");

endmodule : gbsms_top

`default_nettype wire

// >>> logic/gbsms_consts.svh
/*
  Constants of the gain bank and servo mode selector: register offsets,
  field positions of the servo command I/O word, reset values and times.
  Assumes a 100 MHz clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef GBSMS_CONSTS_SVH
`define GBSMS_CONSTS_SVH

// register map, byte addresses
`define GBSMS_ADDR_W 8
`define GBSMS_OFF_CTRL 8'h00
`define GBSMS_OFF_STATUS 8'h04
`define GBSMS_OFF_CMDWORD 8'h08
`define GBSMS_OFF_PARAM 8'h40

// control and status fields
`define GBSMS_CTRL_RESTART_BIT 8
`define GBSMS_STAT_SERVO_BIT 8
`define GBSMS_STAT_AUTO_BIT 9
`define GBSMS_STAT_SETTLED_BIT 10
`define GBSMS_STAT_WARN_BIT 16

// servo command I/O word fields
`define GBSMS_CMD_GSEL_LSB 8
`define GBSMS_CMD_SVMOD_BIT 30
`define GBSMS_CMD_NCL_BIT 7
`define GBSMS_CMD_PCL_BIT 6
`define GBSMS_CMD_PPI_BIT 4
`define GBSMS_CMD_USED_MASK 32'h4000_0fd0

// lowest digit of the automatic switching setting
`define GBSMS_AUTO_OFF 4'h0
`define GBSMS_AUTO_ON 4'h1

// gain parameters
`define GBSMS_PW 16
`define GBSMS_PARAM_RST 16'h0000

// timing
`define GBSMS_CLK_PERIOD_NS 10
`define GBSMS_SETTLE_TIME_NS 2000000
`define GBSMS_SETTLE_CYCLES \
  ((`GBSMS_SETTLE_TIME_NS + `GBSMS_CLK_PERIOD_NS - 1) / `GBSMS_CLK_PERIOD_NS)
`define GBSMS_SETTLE_W 18

// bus responses
`define GBSMS_RESP_OKAY 2'b00
`define GBSMS_RESP_SLVERR 2'b10

`endif

// >>> logic/gbsms_pkg.sv
/*
  Types of the gain bank and servo mode selector: bus carriers, the gain
  set, and the state records of the top and of the bus slave.
  Assumes gbsms_consts.svh on the include path.
*/
`include "gbsms_consts.svh"

package gbsms_pkg;

  // master to slave, AXI4-Lite
  typedef struct packed {
    logic awvalid;
    logic [`GBSMS_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`GBSMS_ADDR_W-1:0] araddr;
    logic rready;
  } gbsms_axi_req_t;

  // slave to master, AXI4-Lite
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gbsms_axi_rsp_t;

  // one register write handed to the block
  typedef struct packed {
    logic en;
    logic [`GBSMS_ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } gbsms_wr_t;

  // gain values of the active bank
  typedef struct packed {
    logic [`GBSMS_PW-1:0] spd_gain;
    logic [`GBSMS_PW-1:0] spd_integ;
    logic [`GBSMS_PW-1:0] pos_gain;
    logic [`GBSMS_PW-1:0] trq_filt;
  } gbsms_gain_t;

  typedef struct packed {
    logic aw_hold;
    logic [`GBSMS_ADDR_W-1:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    gbsms_axi_rsp_t rsp;
  } gbsms_slv_state_t;

  typedef struct packed {
    logic [3:0] pend_sel;
    logic [3:0] auto_sel;
    logic [3:0] gain_field;
    logic servo_req;
    logic servo_on;
    logic warn;
    logic [31:0] last_word;
    logic [`GBSMS_SETTLE_W-1:0] settle_cnt;
    logic settled;
    logic [15:0][`GBSMS_PW-1:0] params;
    gbsms_gain_t gain_out;
  } gbsms_state_t;

endpackage : gbsms_pkg

// >>> logic/gbsms_axil_slave.sv
/*
  AXI4-Lite slave of the gain bank selector: takes write address and data
  in either order, hands one write at a time to the block, answers reads
  with the word the block presents for the read address.
  Assumes the block decodes addresses combinationally for rd_data/errors.
*/
`include "gbsms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gbsms_axil_slave (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire gbsms_pkg::gbsms_axi_req_t req,
  output gbsms_pkg::gbsms_axi_rsp_t rsp,
  output gbsms_pkg::gbsms_wr_t wr,
  input wire logic wr_err,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import gbsms_pkg::*;

  gbsms_slv_state_t s;
  gbsms_slv_state_t next_s;

  // write goes through once address and data are both held
  assign wr.en = s.aw_hold && s.w_hold && !s.rsp.bvalid;
  assign wr.addr = s.awaddr;
  assign wr.data = s.wdata;
  assign wr.strb = s.wstrb;
  assign rsp = s.rsp;

  // channel handshakes; readies are registered from the next hold state and, for arready, the next rvalid
  always_comb begin
    next_s = s;
    if (req.awvalid && s.rsp.awready) begin
      next_s.aw_hold = 1'b1;
      next_s.awaddr = req.awaddr;
    end
    if (req.wvalid && s.rsp.wready) begin
      next_s.w_hold = 1'b1;
      next_s.wdata = req.wdata;
      next_s.wstrb = req.wstrb;
    end
    if (s.rsp.bvalid && req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (wr.en) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wr_err ? `GBSMS_RESP_SLVERR : `GBSMS_RESP_OKAY;
    end
    if (s.rsp.rvalid && req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = rd_data;
      next_s.rsp.rresp = rd_err ? `GBSMS_RESP_SLVERR : `GBSMS_RESP_OKAY;
    end
    next_s.rsp.awready = !next_s.aw_hold;
    next_s.rsp.wready = !next_s.w_hold;
    next_s.rsp.arready = !next_s.rsp.rvalid;
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

endmodule : gbsms_axil_slave

`default_nettype wire

// >>> tb/gbsms_host_model.sv
/*
  host model: sends one command word per request, stops motion while
  a new word settles, then starts the requested motion commands.
  assumes gbsms_consts.svh on the include path and one clock.
*/
`include "gbsms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module gbsms_host_model #(
  parameter int WAIT_CYCLES = 22
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic raw,
  input wire logic [31:0] word_in,
  input wire logic [2:0] motion_in,
  output logic cmd_valid,
  output logic [31:0] word,
  output logic [2:0] motion,
  output logic done
);
  logic busy;
  int cnt;

  // one word per request, motion only after the wait
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      word <= 32'h0;
      motion <= 3'h0;
      busy <= 1'b0;
      cnt <= 0;
    end else begin
      cmd_valid <= 1'b0;
      if (cmd_valid) begin
        word <= ~word; // word not held outside the strobe
      end
      if (go && !busy) begin
        busy <= 1'b1;
        cmd_valid <= 1'b1;
        word <= raw ? word_in : word_in & `GBSMS_CMD_USED_MASK;
        motion <= 3'h0;
        cnt <= WAIT_CYCLES;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          motion <= motion_in;
        end
      end else if (!go) begin
        busy <= 1'b0;
      end
    end
  end

  // request finished once motion is applied
  assign done = busy && cnt == 0;
endmodule : gbsms_host_model
`default_nettype wire

// >>> tb/test_gain_bank_servo_mode_select.sv
/*
  testbench of the gain bank and servo mode selector: registers over
  AXI4-Lite, command words through the host model, random fields.
  assumes the logic/ files and the host model compiled first.
*/
`include "gbsms_consts.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module test_gain_bank_servo_mode_select;
  import gbsms_pkg::*;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic go = 1'b0;
  logic raw = 1'b0;
  logic [31:0] word_in = 32'h0;
  logic [2:0] motion_in = 3'h0;
  gbsms_axi_req_t axi_req = '0;
  gbsms_axi_rsp_t axi_rsp;
  gbsms_gain_t active_gains;
  logic cmd_valid, done, servo_mode_on, servo_mode_warning, bank_settled;
  logic [31:0] word;
  logic [2:0] motion;
  logic [1:0] active_bank;
  wire [2:0] reqs;
  logic [31:0] lfsr = 32'h2463;
  logic [15:0] p [16];
  logic [3:0] field = 4'h0;
  logic auto_on = 1'b0;
  logic warn_exp = 1'b0;
  int low_cycles = 0;
  int miscompares = 0;
  int n_compared = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  gbsms_host_model #(.WAIT_CYCLES(SETTLE + 2)) u_host (
    .clk(clk), .nrst(nrst), .go(go), .raw(raw), .word_in(word_in),
    .motion_in(motion_in), .cmd_valid(cmd_valid), .word(word), .motion(motion),
    .done(done));

  gbsms_top #(.SETTLE_CYCLES(SETTLE)) dut (
    .clk(clk), .nrst(nrst), .ce(ce), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .cmd_valid(cmd_valid), .servo_command_io_word(word),
    .interpolation_feed_command(motion[0]), .spindle_orientation_command(motion[1]),
    .quick_orientation_command(motion[2]), .active_gains(active_gains),
    .active_bank(active_bank), .servo_mode_on(servo_mode_on),
    .servo_mode_warning(servo_mode_warning), .bank_settled(bank_settled),
    .reverse_torque_limit_request(reqs[2]), .forward_torque_limit_request(reqs[1]),
    .speed_loop_p_control_request(reqs[0]));

  // counts cycles with the bank not yet settled
  always @(posedge clk) begin
    if (bank_settled === 1'b0) begin
      low_cycles <= low_cycles + 1;
    end
  end

  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step

  task automatic report_and_stop();
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit aw;
    bit w;
    bit fin;
    aw = 1'b0;
    w = 1'b0;
    fin = 1'b0;
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= s;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (!aw && axi_rsp.awready === 1'b1) begin
        aw = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w && axi_rsp.wready === 1'b1) begin
        w = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
      if (axi_rsp.bvalid === 1'b1) begin
        fin = 1'b1;
        axi_req.bready <= 1'b0;
        `CHK("bresp", er, axi_rsp.bresp)
      end
    end
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
                        input string nm);
    bit ar;
    bit fin;
    ar = 1'b0;
    fin = 1'b0;
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    while (!fin) begin
      @(posedge clk);
      if (!ar && axi_rsp.arready === 1'b1) begin
        ar = 1'b1;
        axi_req.arvalid <= 1'b0;
      end
      if (axi_rsp.rvalid === 1'b1) begin
        fin = 1'b1;
        axi_req.rready <= 1'b0;
        `CHK(nm, ed, axi_rsp.rdata)
        `CHK("rresp", er, axi_rsp.rresp)
      end
    end
    @(posedge clk);
  endtask : axi_rd

  // one command word through the host, then every output checked
  task automatic send(input logic [31:0] w, input logic [2:0] m, input logic rw);
    int b;
    int l0;
    bit chg;
    b = w[9:8];
    l0 = low_cycles;
    chg = w[11:8] !== field;
    field = w[11:8];
    go <= 1'b1;
    word_in <= w;
    motion_in <= m;
    raw <= rw;
    @(posedge clk);
    while (done !== 1'b1) @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    if (auto_on && m != 3'h0 && !w[30]) warn_exp = 1'b1;
    `CHK("bank", w[9:8], active_bank)
    `CHK("gains", {p[4*b], p[4*b+1], p[4*b+2], p[4*b+3]}, active_gains)
    `CHK("servo", w[30] | (auto_on & (m != 3'h0)), servo_mode_on)
    `CHK("warning", warn_exp, servo_mode_warning)
    `CHK("requests", {w[7], w[6], w[4]}, reqs)
    `CHK("settle", chg ? SETTLE : 0, low_cycles - l0)
  endtask : send

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  // main sequence
  initial begin
    logic [31:0] d;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("servo", 1'b0, servo_mode_on)
    axi_rd(`GBSMS_OFF_STATUS, 32'h400, `GBSMS_RESP_OKAY, "status");
    axi_rd(`GBSMS_OFF_CTRL, 32'h0, `GBSMS_RESP_OKAY, "ctrl");
    axi_rd(8'h20, 32'h0, `GBSMS_RESP_SLVERR, "unmapped");
    axi_wr(8'h20, 32'hffff_ffff, 4'hf, `GBSMS_RESP_SLVERR);
    $display("test reset_and_map done");
    for (int i = 0; i < 16; i++) begin
      lfsr = step(lfsr);
      p[i] = lfsr[15:0];
      axi_wr(8'h40 + 8'(4 * i), lfsr, 4'hf, `GBSMS_RESP_OKAY);
    end
    axi_wr(8'h40, 32'hffff_ffff, 4'h1, `GBSMS_RESP_OKAY);
    p[0][7:0] = 8'hff;
    for (int i = 0; i < 16; i++) begin
      axi_rd(8'h40 + 8'(4 * i), {16'h0, p[i]}, `GBSMS_RESP_OKAY, "param");
    end
    `CHK("gains", {p[0], p[1], p[2], p[3]}, active_gains)
    $display("test params done");
    // clock enable low for a few cycles: nothing may move
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    `CHK("frozen gains", {p[0], p[1], p[2], p[3]}, active_gains)
    axi_rd(`GBSMS_OFF_STATUS, 32'h400, `GBSMS_RESP_OKAY, "frozen status");
    $display("test freeze done");
    for (int k = 0; k < 12; k++) begin
      lfsr = step(lfsr);
      d = lfsr;
      d[9:8] = 2'(k);
      send(d, d[30] ? lfsr[14:12] : 3'h0, k[0]);
      axi_rd(`GBSMS_OFF_CMDWORD, d & `GBSMS_CMD_USED_MASK, `GBSMS_RESP_OKAY, "word");
    end
    $display("test bank_select done");
    axi_wr(`GBSMS_OFF_CTRL, 32'h1, 4'hf, `GBSMS_RESP_OKAY);
    send(32'h0, 3'h1, 1'b0);
    axi_wr(`GBSMS_OFF_CTRL, 32'h101, 4'hf, `GBSMS_RESP_OKAY);
    auto_on = 1'b1;
    axi_rd(`GBSMS_OFF_CTRL, 32'h1, `GBSMS_RESP_OKAY, "ctrl");
    for (int m = 0; m < 3; m++) begin
      send(32'h0000_0200, 3'(1 << m), 1'b0);
      send(32'h4000_0200, 3'(1 << m), 1'b0);
      axi_wr(`GBSMS_OFF_STATUS, 32'h1_0000, 4'h4, `GBSMS_RESP_OKAY);
      warn_exp = 1'b0;
      `CHK("warning", 1'b0, servo_mode_warning)
    end
    send(32'h0, 3'h0, 1'b0);
    axi_wr(`GBSMS_OFF_CTRL, 32'h100, 4'hf, `GBSMS_RESP_OKAY);
    auto_on = 1'b0;
    send(32'h0, 3'h2, 1'b0);
    $display("test auto_switching done");
    report_and_stop();
  end
endmodule : test_gain_bank_servo_mode_select
`default_nettype wire
